// ===== verilog/port7_pkg.sv
// Purpose: constants and types shared by the four-line port block
// Assumes: registers are one byte each, one Avalon word apiece
// Notes: indices are printed offsets; byte address is four times index
package port7_pkg;
  localparam int NUM_LINES = 4;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam int IDX_LSB = 2;
  // register indices (byte address = index * 4)
  localparam logic [15:0] IDX_PIN_CTRL = 16'hFE5C;
  localparam logic [15:0] IDX_IRQ_LOW_PAIR = 16'hFE5D;
  localparam logic [15:0] IDX_IRQ_HIGH_PAIR = 16'hFE5E;
  localparam logic [15:0] IDX_INPUT_SEL = 16'hFE5F;
  localparam logic [15:0] IDX_LATCH_VIEW = 16'hFE60;
  // reset values
  localparam logic [7:0] RST_PIN_CTRL = 8'h00;
  localparam logic [7:0] RST_IRQ_LOW_PAIR = 8'h00;
  localparam logic [7:0] RST_IRQ_HIGH_PAIR = 8'h00;
  localparam logic [7:0] RST_INPUT_SEL = 8'h00;
  // port control layout: data low nibble, direction high nibble
  localparam int DIR_LSB = 4;
  // irq pair layout: source n at bits PAIR_STRIDE*n + field
  localparam int PAIR_STRIDE = 4;
  localparam int F_ENABLE = 0;
  localparam int F_FLAG = 1;
  localparam int F_LEVEL_OR_FALL = 2;
  localparam int F_POLARITY_OR_RISE = 3;
  // input select layout
  localparam int TCNT_SEL_BIT = 0;
  localparam int CAPL_SEL_BIT = 6;
  localparam int CAPH_SEL_BIT = 7;
  // interrupt vectors
  localparam logic [7:0] VEC_IRQ0 = 8'h03;
  localparam logic [7:0] VEC_IRQ1 = 8'h0B;
  localparam logic [7:0] VEC_IRQ2 = 8'h13;
  localparam logic [7:0] VEC_IRQ3 = 8'h1B;
  localparam logic [7:0] VEC_NONE = 8'h00;
  typedef enum {ST_RUN, ST_HOLD, ST_LIGHT} stby_type;
endpackage : port7_pkg

// ===== verilog/port_irq_wakeup_block.sv
// Purpose: four-line port with external interrupts, timer 0 pulses, wake-up
// Assumes: Avalon-MM slave on SYS_CLK_I; pins are asynchronous to the clock
// Notes: every access takes exactly one wait state
// How it works
// - low nibble of port control is output data, high nibble is direction
// - direction 1 drives; line_0 is open drain, others push-pull
// - each data bit also switches the line pull-up on; line_0 pull-up is dropped in standby
// - port control read gives pin levels low, stored directions high
// - read-modify-write uses the stored latch via the latch view register
// - pin levels are readable whatever the direction
// - irq0/irq1 select falling, low level, rising or high level
// - irq2/irq3 select none, falling, rising or both edges
// - flags set on condition; flag and enable request vectors 03h and 0Bh
// - irq2 requests vector 13h and irq3 vector 1Bh
// - flags stay set until software writes zero
// - each flag-setting change on selected line pulses timer count
// - timer source select 1 picks line_3, 0 picks line_2
// - flag-setting changes pulse capture low or capture high
// - capture low picks line_0 or line_2, high picks line_1 or line_3
// - level mode capture on line_0/1 pulses every cycle while level holds
// - irq2 flag with enable wakes from standby, irq0/irq1 only in level mode; irq3 never does
// - after wake, light standby lasts until interrupt is accepted
// - line_0 and line_1 wake only in level mode
// - in standby line_2 ignores edges toward its level at entry
`timescale 1ns/1ns
module port_irq_wakeup_block (
  input wire logic SYS_CLK_I,
  input wire logic RST_B_I,
  input wire logic [port7_pkg::ADDR_W-1:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [port7_pkg::DATA_W-1:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [port7_pkg::DATA_W-1:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  input wire logic [port7_pkg::NUM_LINES-1:0] LINE_IN_I,
  output logic [port7_pkg::NUM_LINES-1:0] LINE_OUT_O,
  output logic [port7_pkg::NUM_LINES-1:0] LINE_OE_O,
  output logic [port7_pkg::NUM_LINES-1:0] LINE_PULLUP_O,
  output logic [port7_pkg::NUM_LINES-1:0] IRQ_REQ_O,
  output logic [7:0] IRQ_VECTOR_O,
  input wire logic IRQ_ACK_I,
  input wire logic HOLD_REQ_I,
  output logic STANDBY_O,
  output logic LIGHT_STBY_O,
  output logic WAKE_O,
  output logic TIMER_COUNT_O,
  output logic CAPTURE_LOW_O,
  output logic CAPTURE_HIGH_O
);
  import port7_pkg::*;

  logic [7:0] pin_ctrl_r;
  logic [7:0] irq01_r;
  logic [7:0] irq23_r;
  logic [7:0] isel_r;
  logic ack_r;
  logic [DATA_W-1:0] rdata_r;
  logic [NUM_LINES-1:0] sync1_r;
  logic [NUM_LINES-1:0] sync2_r;
  logic [NUM_LINES-1:0] sync3_r;
  logic [NUM_LINES-1:0] lvl_r;
  logic [NUM_LINES-1:0] lvl_prev_r;
  logic line2_ref_r;
  stby_type st_r;
  stby_type st_nxt;
  logic [NUM_LINES-1:0] irq_req_r;
  logic [7:0] vec_r;
  logic wake_r;
  logic tcnt_r;
  logic capl_r;
  logic caph_r;

  // bus decode: one wait state, then the access completes
  wire req = AVS_READ_I | AVS_WRITE_I;
  wire [15:0] idx = AVS_ADDRESS_I[IDX_LSB +: 16];
  wire wr_go = AVS_WRITE_I & ack_r & AVS_BYTEENABLE_I[0];
  wire [7:0] wbyte = AVS_WRITEDATA_I[7:0];
  wire hit_pin = (idx == IDX_PIN_CTRL);
  wire hit_latch = (idx == IDX_LATCH_VIEW);
  wire hit_i01 = (idx == IDX_IRQ_LOW_PAIR);
  wire hit_i23 = (idx == IDX_IRQ_HIGH_PAIR);
  wire hit_isl = (idx == IDX_INPUT_SEL);
  wire wr_pin = wr_go & (hit_pin | hit_latch);
  wire wr_i01 = wr_go & hit_i01;
  wire wr_i23 = wr_go & hit_i23;
  wire wr_isl = wr_go & hit_isl;
  assign AVS_WAITREQUEST_O = req & ~ack_r;

  // field views
  wire [3:0] out_data = pin_ctrl_r[3:0];
  wire [3:0] dir = pin_ctrl_r[DIR_LSB +: 4];
  wire in_hold = (st_r == ST_HOLD);

  // pin levels low, stored directions high; regardless of direction
  wire [7:0] pin_view = {dir, lvl_r};
  wire [7:0] latch_view = pin_ctrl_r;
  // unmapped indices read as zero
  wire [7:0] rd_byte = hit_pin ? pin_view :
                       hit_latch ? latch_view :
                       hit_i01 ? irq01_r :
                       hit_i23 ? irq23_r :
                       hit_isl ? isel_r : 8'h00;

  // bus handshake; read data is caught in the wait cycle so it stands at release
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ack_r <= 1'b0;
      rdata_r <= '0;
    end else begin
      ack_r <= req & ~ack_r;
      if (AVS_READ_I && !ack_r) begin
        rdata_r <= {24'h000000, rd_byte};
      end
    end
  end
  assign AVS_READDATA_O = rdata_r;

  // three-stage sampler; a change counts once stages two and three agree
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
      lvl_r <= '0;
      lvl_prev_r <= '0;
    end else begin
      sync1_r <= LINE_IN_I;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      lvl_prev_r <= lvl_r;
      for (int k = 0; k < NUM_LINES; k++) begin
        if (sync2_r[k] == sync3_r[k]) begin
          lvl_r[k] <= sync3_r[k];
        end
      end
    end
  end

  // per-line edges from current and previous filtered samples
  logic [NUM_LINES-1:0] rise;
  logic [NUM_LINES-1:0] fall;
  genvar g;
  generate
    for (g = 0; g < NUM_LINES; g++) begin : g_edge
      assign rise[g] = lvl_r[g] & ~lvl_prev_r[g];
      assign fall[g] = ~lvl_r[g] & lvl_prev_r[g];
      // data drives; line_0 only pulls low
      if (g == 0) begin : g_od
        assign LINE_OUT_O[g] = 1'b0;
        assign LINE_OE_O[g] = dir[g] & ~out_data[g];
      end else begin : g_pp
        assign LINE_OUT_O[g] = out_data[g];
        assign LINE_OE_O[g] = dir[g];
      end
    end
  endgenerate
  // pull-up follows data; line_0 pull-up is dropped in standby
  assign LINE_PULLUP_O = out_data & {3'b111, ~in_hold};

  // level/edge detection for line_0 and line_1
  wire [1:0] lv_sel = {irq01_r[PAIR_STRIDE + F_LEVEL_OR_FALL], irq01_r[F_LEVEL_OR_FALL]};
  wire [1:0] lh_sel = {irq01_r[PAIR_STRIDE + F_POLARITY_OR_RISE],
                       irq01_r[F_POLARITY_OR_RISE]};
  logic [1:0] det01;
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      if (lv_sel[k]) begin
        det01[k] = (lvl_r[k] == lh_sel[k]);
      end else begin
        det01[k] = lh_sel[k] ? rise[k] : fall[k];
      end
    end
  end

  // edge selection for line_2 and line_3
  wire fall_en2 = irq23_r[F_LEVEL_OR_FALL];
  wire rise_en2 = irq23_r[F_POLARITY_OR_RISE];
  wire fall_en3 = irq23_r[PAIR_STRIDE + F_LEVEL_OR_FALL];
  wire rise_en3 = irq23_r[PAIR_STRIDE + F_POLARITY_OR_RISE];
  // edges toward the level held at standby entry are ignored
  wire blk_rise2 = in_hold & line2_ref_r;
  wire blk_fall2 = in_hold & ~line2_ref_r;
  wire det2 = (rise_en2 & rise[2] & ~blk_rise2) | (fall_en2 & fall[2] & ~blk_fall2);
  wire det3 = (rise_en3 & rise[3]) | (fall_en3 & fall[3]);
  wire [3:0] det = {det3, det2, det01};

  // flag and enable views
  wire [3:0] flag = {irq23_r[PAIR_STRIDE + F_FLAG], irq23_r[F_FLAG],
                     irq01_r[PAIR_STRIDE + F_FLAG], irq01_r[F_FLAG]};
  wire [3:0] ena = {irq23_r[PAIR_STRIDE + F_ENABLE], irq23_r[F_ENABLE],
                    irq01_r[PAIR_STRIDE + F_ENABLE], irq01_r[F_ENABLE]};

  // flags: hardware set wins over a software clear in the same cycle
  logic [7:0] irq01_nxt;
  logic [7:0] irq23_nxt;
  always_comb begin
    irq01_nxt = wr_i01 ? wbyte : irq01_r;
    irq23_nxt = wr_i23 ? wbyte : irq23_r;
    irq01_nxt[F_FLAG] = irq01_nxt[F_FLAG] | det[0];
    irq01_nxt[PAIR_STRIDE + F_FLAG] = irq01_nxt[PAIR_STRIDE + F_FLAG] | det[1];
    irq23_nxt[F_FLAG] = irq23_nxt[F_FLAG] | det[2];
    irq23_nxt[PAIR_STRIDE + F_FLAG] = irq23_nxt[PAIR_STRIDE + F_FLAG] | det[3];
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      pin_ctrl_r <= RST_PIN_CTRL;
      irq01_r <= RST_IRQ_LOW_PAIR;
      irq23_r <= RST_IRQ_HIGH_PAIR;
      isel_r <= RST_INPUT_SEL;
    end else begin
      if (wr_pin) begin
        pin_ctrl_r <= wbyte;
      end
      irq01_r <= irq01_nxt;
      irq23_r <= irq23_nxt;
      if (wr_isl) begin
        isel_r <= wbyte;
      end
    end
  end

  // requests and the vector of the lowest pending source
  wire [3:0] req_now = flag & ena;
  wire [7:0] vec_now = req_now[0] ? VEC_IRQ0 :
                       req_now[1] ? VEC_IRQ1 :
                       req_now[2] ? VEC_IRQ2 :
                       req_now[3] ? VEC_IRQ3 : VEC_NONE;
  // wake sources; irq3 is left out on purpose
  wire wake_now = (req_now[0] & lv_sel[0]) | (req_now[1] & lv_sel[1]) | req_now[2];
  wire tcnt_now = isel_r[TCNT_SEL_BIT] ? det[3] : det[2];
  wire capl_now = isel_r[CAPL_SEL_BIT] ? det[0] : det[2];
  wire caph_now = isel_r[CAPH_SEL_BIT] ? det[1] : det[3];

  // pulses follow detection, so level mode repeats each cycle
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      irq_req_r <= '0;
      vec_r <= VEC_NONE;
      wake_r <= 1'b0;
      tcnt_r <= 1'b0;
      capl_r <= 1'b0;
      caph_r <= 1'b0;
    end else begin
      irq_req_r <= req_now;
      vec_r <= vec_now;
      wake_r <= wake_now;
      tcnt_r <= tcnt_now;
      capl_r <= capl_now;
      caph_r <= caph_now;
    end
  end
  assign IRQ_REQ_O = irq_req_r;
  assign IRQ_VECTOR_O = vec_r;
  assign WAKE_O = wake_r;
  assign TIMER_COUNT_O = tcnt_r;
  assign CAPTURE_LOW_O = capl_r;
  assign CAPTURE_HIGH_O = caph_r;

  // standby sequence: hold, then light standby until the ack
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_RUN: begin
        if (HOLD_REQ_I) begin
          st_nxt = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (wake_r) begin
          st_nxt = ST_LIGHT;
        end
      end
      ST_LIGHT: begin
        if (IRQ_ACK_I) begin
          st_nxt = ST_RUN;
        end
      end
      default: st_nxt = ST_RUN;
    endcase
  end

  // line_2 level is frozen at hold entry for the edge blocking
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      st_r <= ST_RUN;
      line2_ref_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      if (st_r == ST_RUN && st_nxt == ST_HOLD) begin
        line2_ref_r <= lvl_r[2];
      end
    end
  end
  assign STANDBY_O = in_hold;
  assign LIGHT_STBY_O = (st_r == ST_LIGHT);

  // checks kept beside the logic
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_B_I);

  sequence s_req_start;
    req && !ack_r;
  endsequence
  sequence s_one_wait;
    AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O;
  endsequence
  a_bus_one_wait: assert property (s_req_start |-> s_one_wait)
    else $error("access did not complete after one wait state");
  a_pin_read_view: assert property (
    AVS_READ_I && !ack_r && hit_pin |=> AVS_READDATA_O[7:0] == {$past(dir), $past(lvl_r)})
    else $error("pin control read mismatch");
  a_latch_view: assert property (
    AVS_READ_I && !ack_r && hit_latch |=> AVS_READDATA_O[7:0] == $past(pin_ctrl_r))
    else $error("latch view read mismatch");
  a_opendrain_line0: assert property (
    LINE_OE_O[0] == (dir[0] && !out_data[0]) && LINE_OUT_O[0] == 1'b0)
    else $error("line 0 not open drain");
  a_flag_sticky: assert property (
    flag[0] && !wr_i01 |=> flag[0])
    else $error("flag cleared without software write");
  a_set_wins: assert property (
    det[1] && wr_i01 |=> flag[1])
    else $error("set lost to clear");
  a_line2_block: assert property (
    in_hold && line2_ref_r && rise[2] && !fall[2] |-> !det2)
    else $error("line 2 rise accepted in standby");
  a_irq3_nowake: assert property (
    req_now == 4'b1000 |=> !WAKE_O)
    else $error("irq3 released standby");
  a_edge_nowake: assert property (
    req_now[3:1] == 3'b000 && !lv_sel[0] |=> !WAKE_O)
    else $error("edge mode line 0 woke device");
  sequence s_low_level3;
    (isel_r[CAPL_SEL_BIT] && lv_sel[0] && !lh_sel[0] && !lvl_r[0]) [*3];
  endsequence
  a_capt_repeat: assert property (
    s_low_level3 |=> CAPTURE_LOW_O && $past(CAPTURE_LOW_O) && $past(CAPTURE_LOW_O, 2))
    else $error("level capture not every cycle");
  a_tcnt_line3: assert property (
    isel_r[TCNT_SEL_BIT] && det[3] |=> TIMER_COUNT_O)
    else $error("missing timer count pulse");
  a_light_hold: assert property (
    LIGHT_STBY_O && !IRQ_ACK_I |=> LIGHT_STBY_O)
    else $error("light standby left before ack");
endmodule : port_irq_wakeup_block

// ===== verification/pin_source_model.sv
// Purpose: outside signal sources and wire resolution for the four lines
// Assumes: the bench sets source values and enables just after clock edges
// Notes: an undriven line without pull-up wanders every cycle, never holds
`timescale 1ns/1ns
module pin_source_model (
  input wire logic clk_i,
  input wire logic [3:0] out_i,
  input wire logic [3:0] oe_i,
  input wire logic [3:0] pullup_i,
  input wire logic [3:0] ext_val_i,
  input wire logic [3:0] ext_en_i,
  output logic [3:0] level_o
);
  logic [3:0] float_r = 4'h0;
  // a floating line must not look like a stable level
  always @(posedge clk_i) float_r <= ~float_r;
  // device drive wins, then outside source, then pull-up
  always_comb begin
    for (int n = 0; n < 4; n++) begin
      if (oe_i[n]) level_o[n] = out_i[n];
      else if (ext_en_i[n]) level_o[n] = ext_val_i[n];
      else if (pullup_i[n]) level_o[n] = 1'b1;
      else level_o[n] = float_r[n];
    end
  end
endmodule : pin_source_model

// ===== verification/tb.sv
// Purpose: self-checking bench for the four-line port and interrupt block
// Assumes: the slave answers within sixteen cycles; pins pass a short sampling filter
// Notes: expected values come from the rule model functions in here
`timescale 1ns/1ns
module tb;
  import port7_pkg::*;
  logic clk, rst_b, rd, wr, ack, hold, wreq, stby, light, wake, tcnt, capl, caph;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [3:0] be, lout, loe, lpu, lin, req, ev, ee, x, lv;
  logic [7:0] vec, q, d, input_signal_select;
  logic [15:0] pi;
  logic [1:0] m;
  logic a, b, en, f;
  int n_fail = 0, total_checks = 0, n_t = 0, n_cl = 0, n_ch = 0, c0, c1, c2, e;
  logic [7:0] vecs [4] = '{VEC_IRQ0, VEC_IRQ1, VEC_IRQ2, VEC_IRQ3};
  logic [7:0] sv [5] = '{8'h09, 8'h0D, 8'hD0, 8'h01, 8'h50};
  int sl [5] = '{2, 2, 3, 0, 1};
  logic [4:0] sw = 5'b10010;
  logic [4:0] sr = 5'b11110;

  port_irq_wakeup_block i_port_irq_wakeup_block (
    .SYS_CLK_I(clk), .RST_B_I(rst_b), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(be),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wreq), .LINE_IN_I(lin),
    .LINE_OUT_O(lout), .LINE_OE_O(loe), .LINE_PULLUP_O(lpu), .IRQ_REQ_O(req),
    .IRQ_VECTOR_O(vec), .IRQ_ACK_I(ack), .HOLD_REQ_I(hold), .STANDBY_O(stby),
    .LIGHT_STBY_O(light), .WAKE_O(wake), .TIMER_COUNT_O(tcnt),
    .CAPTURE_LOW_O(capl), .CAPTURE_HIGH_O(caph));
  pin_source_model i_pin_source_model (.clk_i(clk), .out_i(lout), .oe_i(loe),
    .pullup_i(lpu), .ext_val_i(ev), .ext_en_i(ee), .level_o(lin));

  // clock and pulse tallies, read by the sequence as differences
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    n_t <= n_t + int'(tcnt);
    n_cl <= n_cl + int'(capl);
    n_ch <= n_ch + int'(caph);
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // outputs are read at the edge, before its updates land; inputs then change by nba
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // one access; the request stands until waitrequest is sampled low at a rising edge,
  // and read data is taken at that same edge
  task automatic bus(input int w, input logic [15:0] idx, input logic [7:0] dv,
                     output logic [7:0] rq);
    logic busy;
    busy = 1'b1;
    rq = 8'h00;
    @(posedge clk);
    addr <= {idx, 2'b00};
    rd <= (w == 0);
    wr <= (w != 0);
    wdata <= {24'h0, dv};
    for (int i = 0; i < 16 && busy; i++) begin
      @(posedge clk);
      // an unknown waitrequest keeps the master waiting
      busy = (wreq !== 1'b0);
      rq = rdata[7:0];
    end
    rd <= 1'b0;
    wr <= 1'b0;
    if (busy) begin
      n_fail++;
      summarize();
    end
  endtask : bus

  // flag after the line goes a then b; level modes also see a
  function automatic logic fexp(input int s, input logic [1:0] mm, input logic aa,
                                input logic bb);
    if (s < 2) begin
      return mm[0] ? (aa == mm[1] || bb == mm[1]) : (aa != bb && bb == mm[1]);
    end
    return (mm[1] && !aa && bb) || (mm[0] && aa && !bb);
  endfunction : fexp

  function automatic int cl(input int v);
    return v > 2 ? 2 : v;
  endfunction : cl

  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    summarize();
  end

  initial begin
    {rst_b, rd, wr, ack, hold} = 5'b0;
    addr = '0;
    wdata = '0;
    be = 4'hF;
    ev = 4'h0;
    ee = 4'hF;
    void'($urandom(32'hcce20c4b));
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    // reset values, unmapped place and disabled byte lane
    for (int i = 0; i < 6; i++) begin
      bus(0, IDX_PIN_CTRL + 16'(i), 8'h00, q);
      chk(q, 0);
    end
    bus(1, 16'hFE61, 8'hFF, q);
    bus(0, 16'hFE61, 8'h00, q);
    chk(q, 0);
    be <= 4'hE;
    bus(1, IDX_INPUT_SEL, 8'hC1, q);
    be <= 4'hF;
    bus(0, IDX_INPUT_SEL, 8'h00, q);
    chk(q, 0);
    $display("test reset done");
    // drive, pull-up and readback of random settings
    for (int k = 0; k < 8; k++) begin
      d = 8'($urandom);
      x = 4'($urandom);
      ee <= ~d[7:4];
      ev <= x;
      bus(1, IDX_PIN_CTRL, d, q);
      cyc(8);
      chk(loe, d[7:4] & {3'b111, ~d[0]});
      chk(lout, d[3:0] & 4'hE);
      chk(lpu, d[3:0]);
      lv = (d[7:4] & d[3:0]) | (~d[7:4] & x);
      bus(0, IDX_PIN_CTRL, 8'h00, q);
      chk(q, {d[7:4], lv});
      bus(0, IDX_LATCH_VIEW, 8'h00, q);
      chk(q, d);
    end
    $display("test port done");
    bus(1, IDX_PIN_CTRL, 8'h00, q);
    ee <= 4'hF;
    // every mode of every source, both levels before and after
    for (int s = 0; s < 4; s++) begin
      for (int k = 0; k < 16; k++) begin
        m = k[3:2];
        a = k[0];
        b = k[1];
        en = 1'($urandom);
        input_signal_select = 8'($urandom) & 8'hC1;
        pi = s < 2 ? IDX_IRQ_LOW_PAIR : IDX_IRQ_HIGH_PAIR;
        bus(1, IDX_INPUT_SEL, input_signal_select, q);
        bus(1, pi ^ 16'h0003, 8'h00, q);
        // a level mode left from the last pass may set the flag during this clear,
        // so the config write below clears it again once the line is settled
        bus(1, pi, 8'h00, q);
        ev[s] <= a;
        cyc(10);
        bus(1, pi, {4'h0, m, 1'b0, en} << (4 * (s % 2)), q);
        {c0, c1, c2} = {n_t, n_cl, n_ch};
        ev[s] <= b;
        cyc(12);
        bus(0, pi, 8'h00, q);
        f = fexp(s, m, a, b);
        e = f ? ((s < 2 && m[0]) ? 2 : 1) : 0;
        chk(q[4 * (s % 2) + 1], f);
        chk(req[s], f & en);
        chk(vec, (f & en) ? vecs[s] : VEC_NONE);
        chk(cl(n_t - c0), (s == (input_signal_select[0] ? 3 : 2)) ? e : 0);
        chk(cl(n_cl - c1), (s == (input_signal_select[6] ? 0 : 2)) ? e : 0);
        chk(cl(n_ch - c2), (s == (input_signal_select[7] ? 1 : 3)) ? e : 0);
      end
    end
    $display("test irq done");
    // wake from standby per source, then a forced level wake
    for (int k = 0; k < 5; k++) begin
      ev <= 4'hF;
      cyc(10);
      bus(1, IDX_IRQ_LOW_PAIR, 8'h00, q);
      bus(1, IDX_IRQ_HIGH_PAIR, 8'h00, q);
      bus(1, sl[k] < 2 ? IDX_IRQ_LOW_PAIR : IDX_IRQ_HIGH_PAIR, sv[k], q);
      hold <= 1'b1;
      cyc(2);
      chk(stby, 1);
      ev[sl[k]] <= 1'b0;
      cyc(10);
      ev[sl[k]] <= 1'b1;
      cyc(10);
      chk(light, sw[k]);
      chk(wake, sw[k]);
      chk(stby, !sw[k]);
      chk(req[sl[k]], sr[k]);
      hold <= 1'b0;
      bus(1, IDX_IRQ_LOW_PAIR, 8'h0D, q);
      cyc(10);
      chk(light, 1);
      ack <= 1'b1;
      cyc(1);
      ack <= 1'b0;
      cyc(2);
      chk({stby, light}, 0);
    end
    $display("test standby done");
    summarize();
  end
endmodule : tb
